// >>> inc/spicr_pkg.sv
// Purpose: Constants and types for the SPI control and clock-rate block.
// Assumes: One system clock; register strobes are one cycle wide.
// Notes:   Offsets address the special function register space.
// Summary of operation
// - As slave, sample the master-out line at the middle of each bit.
// - As master, sample the slave-out line in the final system clock of each bit.
// - Set the transfer done flag after each transfer; only software clears it.
// - Data write while transmit buffer full is dropped and flags a collision.
// - Master with select mode 01 and select low flags a mode fault.
// - Slave completing a byte while receive buffer is full flags an overrun.
// - Select mode 00 three-wire, 01 select input, 1x select output.
// - Buffer empty clears on a data write, sets when data enters shifter.
// - Port enable bit at 0 disables the port, at 1 enables it.
// - Master serial clock is system clock over twice the sum of divider value and one.
package spicr_pkg;
   localparam logic [7:0] SPICR_ADDR_CFG   = 8'hA1;
   localparam logic [7:0] SPICR_ADDR_CKR   = 8'hA2;
   localparam logic [7:0] SPICR_ADDR_DAT   = 8'hA3;
   localparam logic [7:0] SPICR_ADDR_CTL   = 8'hF8;
   localparam int         CTL_DONE         = 7;
   localparam int         CTL_WRITE_COLLISION_FLAG         = 6;
   localparam int         CTL_MODE_FAULT_FLAG         = 5;
   localparam int         CTL_OVR          = 4;
   localparam int         CTL_SEL_HI       = 3;
   localparam int         CTL_SEL_LO       = 2;
   localparam int         CTL_EN           = 0;
   localparam int         CFG_MST          = 6;
   localparam int         CFG_CPHA         = 5;
   localparam int         CFG_CPOL         = 4;
   localparam logic [1:0] SEL_RESET        = 2'h1;
   localparam logic [1:0] SEL_3WIRE        = 2'h0;
   localparam logic [1:0] SEL_4WIRE_IN     = 2'h1;
   localparam logic [7:0] CKR_RESET        = 8'h00;
   localparam logic [7:0] BYTE_ZERO        = 8'h00;
   localparam logic [2:0] BIT_LAST         = 3'h7;
   localparam int         DATA_W           = 8;
   localparam int         FIFO_DEPTH       = 32;
   typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} spicr_state_t;
endpackage : spicr_pkg

// >>> src/spicr_fifo.sv
// Purpose: Receive FIFO between the shift register and the data port.
// Assumes: DEPTH is a power of two.
// Notes:   Full shows as in_ready low; empty as out_valid low.
`timescale 1ns/1ps
module spicr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             clock,
   input  wire logic             nrst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr_ff, nxt_wptr, rptr_ff, nxt_rptr;
   logic [AW:0]      count_ff, nxt_count;
   logic             push, pop;

   assign in_ready  = (count_ff != (AW+1)'(DEPTH));
   assign out_valid = (count_ff != '0);
   assign out_data  = mem[rptr_ff];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb
   begin
      nxt_wptr  = push ? AW'(wptr_ff + 1'b1) : wptr_ff;
      nxt_rptr  = pop ? AW'(rptr_ff + 1'b1) : rptr_ff;
      nxt_count = count_ff;
      if (push && !pop)
         nxt_count = (AW+1)'(count_ff + 1'b1);
      else if (pop && !push)
         nxt_count = (AW+1)'(count_ff - 1'b1);
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         wptr_ff  <= '0;
         rptr_ff  <= '0;
         count_ff <= '0;
      end
      else
      begin
         wptr_ff  <= nxt_wptr;
         rptr_ff  <= nxt_rptr;
         count_ff <= nxt_count;
      end
   end

   always_ff @(posedge clock)
   begin
      if (push)
         mem[wptr_ff] <= in_data;
   end
endmodule : spicr_fifo

// >>> src/spicr_top.sv
// Purpose: SPI port control, status, clock divider and shift engine.
// Assumes: Register strobes come from the CPU on the system clock.
// Notes:   Pins are resynchronised; MSB is shifted first.
`timescale 1ns/1ps
module spicr_top
   import spicr_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       nrst,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   output logic            port_irq,
   input  wire logic       sck_i,
   output logic            sck_o,
   output logic            sck_oe,
   input  wire logic       mosi_i,
   output logic            mosi_o,
   output logic            mosi_oe,
   input  wire logic       miso_i,
   output logic            miso_o,
   output logic            miso_oe,
   input  wire logic       slave_select_i,
   output logic            slave_select_o,
   output logic            slave_select_oe
);
   spicr_state_t state_ff, nxt_state;
   logic [7:0] ckr_ff, nxt_ckr, shift_ff, nxt_shift, txbuf_ff, nxt_txbuf;
   logic [7:0] cnt_ff, nxt_cnt, rdata_ff, nxt_rdata;
   logic [2:0] bit_ff, nxt_bit;
   logic [1:0] sel_ff, nxt_sel;
   logic [3:0] sync1_ff, sync2_ff;
   logic half_ff, nxt_half, en_ff, nxt_en, mst_ff, nxt_mst;
   logic cpha_ff, nxt_cpha, cpol_ff, nxt_cpol, txe_ff, nxt_txe;
   logic done_ff, nxt_done, write_collision_flag_ff, nxt_write_collision_flag, mode_fault_flag_ff, nxt_mode_fault_flag;
   logic ovr_ff, nxt_ovr, irq_ff, nxt_irq, sckp_ff;
   logic sck_ff, nxt_sck, sckoe_ff, nxt_sckoe, mosi_ff, nxt_mosi;
   logic misooe_ff, nxt_misooe, nsso_ff, nxt_nsso, nssoe_ff, nxt_nssoe;
   logic ev_done, ev_write_collision_flag, ev_mode_fault_flag, ev_ovr, push;
   logic sck_s, mosi_s, miso_s, nss_s, selected, edge_s, sample_edge;
   logic wr_ctl, wr_cfg, wr_ckr, wr_dat, rd_dat;
   logic fifo_in_ready, fifo_out_valid;
   logic [7:0] fifo_out_data;

   assign {nss_s, miso_s, mosi_s, sck_s} = sync2_ff;
   assign wr_ctl = sfr_wr && (sfr_addr == SPICR_ADDR_CTL);
   assign wr_cfg = sfr_wr && (sfr_addr == SPICR_ADDR_CFG);
   assign wr_ckr = sfr_wr && (sfr_addr == SPICR_ADDR_CKR);
   assign wr_dat = sfr_wr && (sfr_addr == SPICR_ADDR_DAT);
   assign rd_dat = sfr_rd && (sfr_addr == SPICR_ADDR_DAT);
   // Three-wire slave is always selected; select-input mode 01 follows the pin; select-output modes 1x are never selected.
   assign selected = (sel_ff == SEL_3WIRE) || (!sel_ff[1] && !nss_s);
   assign edge_s = (sck_s != sckp_ff);
   // Leading edge samples for phase 0, trailing edge for phase 1.
   assign sample_edge = edge_s && ((sck_s != cpol_ff) ^ cpha_ff);

   assign sfr_rdata       = rdata_ff;
   assign port_irq        = irq_ff;
   assign sck_o           = sck_ff;
   assign sck_oe          = sckoe_ff;
   assign mosi_o          = mosi_ff;
   assign mosi_oe         = sckoe_ff;
   assign miso_o          = mosi_ff;
   assign miso_oe         = misooe_ff;
   assign slave_select_o  = nsso_ff;
   assign slave_select_oe = nssoe_ff;

   spicr_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rx_fifo (
      .clock     (clock),
      .nrst      (nrst),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (nxt_shift),
      .out_valid (fifo_out_valid),
      .out_ready (rd_dat),
      .out_data  (fifo_out_data)
   );

   always_comb
   begin
      nxt_state = state_ff;
      nxt_ckr   = ckr_ff;
      nxt_shift = shift_ff;
      nxt_txbuf = txbuf_ff;
      nxt_cnt   = cnt_ff;
      nxt_bit   = bit_ff;
      nxt_half  = half_ff;
      nxt_sel   = sel_ff;
      nxt_en    = en_ff;
      nxt_mst   = mst_ff;
      nxt_cpha  = cpha_ff;
      nxt_cpol  = cpol_ff;
      nxt_txe   = txe_ff;
      ev_done   = 1'b0;
      ev_write_collision_flag   = 1'b0;
      ev_ovr    = 1'b0;
      push      = 1'b0;
      if (wr_ckr)
         nxt_ckr = sfr_wdata;
      if (wr_cfg)
      begin
         nxt_mst  = sfr_wdata[CFG_MST];
         nxt_cpha = sfr_wdata[CFG_CPHA];
         nxt_cpol = sfr_wdata[CFG_CPOL];
      end
      if (wr_ctl)
      begin
         nxt_sel = sfr_wdata[CTL_SEL_HI:CTL_SEL_LO];
         nxt_en  = sfr_wdata[CTL_EN];
      end
      if (wr_dat)
      begin
         if (!txe_ff)
            ev_write_collision_flag = 1'b1;
         else
         begin
            nxt_txbuf = sfr_wdata;
            nxt_txe   = 1'b0;
         end
      end
      ev_mode_fault_flag = mst_ff && (sel_ff == SEL_4WIRE_IN) && !nss_s;
      case (state_ff)
         ST_IDLE:
         begin
            nxt_bit  = '0;
            nxt_cnt  = '0;
            nxt_half = 1'b0;
            // A master waits for receive room instead of overrunning.
            if (en_ff && mst_ff)
            begin
               if (!txe_ff && fifo_in_ready)
               begin
                  nxt_shift = txbuf_ff;
                  nxt_txe   = 1'b1;
                  nxt_state = ST_MASTER;
               end
            end
            else if (en_ff && selected)
            begin
               if (!txe_ff)
               begin
                  nxt_shift = txbuf_ff;
                  nxt_txe   = 1'b1;
               end
               nxt_state = ST_SLAVE;
            end
         end
         ST_MASTER:
         begin
            if (cnt_ff == ckr_ff)
            begin
               nxt_cnt  = '0;
               nxt_half = !half_ff;
               if (half_ff)
               begin
                  // Final system clock of the bit samples the input.
                  nxt_shift = {shift_ff[6:0], miso_s};
                  nxt_bit   = 3'(bit_ff + 1'b1);
                  if (bit_ff == BIT_LAST)
                  begin
                     push      = 1'b1;
                     ev_done   = 1'b1;
                     nxt_state = ST_IDLE;
                  end
               end
            end
            else
               nxt_cnt = 8'(cnt_ff + 1'b1);
         end
         ST_SLAVE:
         begin
            if (!selected)
               nxt_state = ST_IDLE;
            else if (sample_edge)
            begin
               nxt_shift = {shift_ff[6:0], mosi_s};
               nxt_bit   = 3'(bit_ff + 1'b1);
               if (bit_ff == BIT_LAST)
               begin
                  push      = 1'b1;
                  ev_ovr    = !fifo_in_ready;
                  ev_done   = 1'b1;
                  nxt_state = ST_IDLE;
               end
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
      if (!en_ff)
         nxt_state = ST_IDLE;
   end

   always_comb
   begin
      nxt_done = (wr_ctl ? sfr_wdata[CTL_DONE] : done_ff) | ev_done;
      nxt_write_collision_flag = (wr_ctl ? sfr_wdata[CTL_WRITE_COLLISION_FLAG] : write_collision_flag_ff) | ev_write_collision_flag;
      nxt_mode_fault_flag = (wr_ctl ? sfr_wdata[CTL_MODE_FAULT_FLAG] : mode_fault_flag_ff) | ev_mode_fault_flag;
      nxt_ovr  = (wr_ctl ? sfr_wdata[CTL_OVR] : ovr_ff) | ev_ovr;
      nxt_irq  = nxt_done | nxt_write_collision_flag | nxt_mode_fault_flag | nxt_ovr;
      nxt_sck  = cpol_ff;
      if (nxt_state == ST_MASTER)
         nxt_sck = cpol_ff ^ nxt_half ^ cpha_ff;
      nxt_sckoe  = en_ff && mst_ff;
      nxt_mosi   = nxt_shift[7];
      nxt_misooe = en_ff && !mst_ff && selected;
      nxt_nsso   = sel_ff[0];
      nxt_nssoe  = sel_ff[1];
      nxt_rdata  = rdata_ff;
      if (sfr_rd)
      begin
         case (sfr_addr)
            SPICR_ADDR_CTL: nxt_rdata = {done_ff, write_collision_flag_ff, mode_fault_flag_ff, ovr_ff,
                                         sel_ff, txe_ff, en_ff};
            SPICR_ADDR_CFG: nxt_rdata = {state_ff != ST_IDLE, mst_ff, cpha_ff,
                                         cpol_ff, selected && !mst_ff, nss_s,
                                         txe_ff && state_ff == ST_IDLE,
                                         !fifo_out_valid};
            SPICR_ADDR_CKR: nxt_rdata = ckr_ff;
            SPICR_ADDR_DAT: nxt_rdata = fifo_out_data;
            default:        nxt_rdata = BYTE_ZERO;
         endcase
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         state_ff <= ST_IDLE;
         ckr_ff   <= CKR_RESET;
         {shift_ff, txbuf_ff, cnt_ff, rdata_ff} <= '0;
         {bit_ff, half_ff, en_ff, mst_ff, cpha_ff, cpol_ff} <= '0;
         sel_ff   <= SEL_RESET;
         txe_ff   <= 1'b1;
         {done_ff, write_collision_flag_ff, mode_fault_flag_ff, ovr_ff, irq_ff} <= '0;
         {sck_ff, sckoe_ff, mosi_ff, misooe_ff, nsso_ff, nssoe_ff} <= '0;
         {sync1_ff, sync2_ff, sckp_ff} <= '0;
      end
      else
      begin
         state_ff  <= nxt_state;
         ckr_ff    <= nxt_ckr;
         shift_ff  <= nxt_shift;
         txbuf_ff  <= nxt_txbuf;
         cnt_ff    <= nxt_cnt;
         rdata_ff  <= nxt_rdata;
         bit_ff    <= nxt_bit;
         half_ff   <= nxt_half;
         en_ff     <= nxt_en;
         mst_ff    <= nxt_mst;
         cpha_ff   <= nxt_cpha;
         cpol_ff   <= nxt_cpol;
         sel_ff    <= nxt_sel;
         txe_ff    <= nxt_txe;
         done_ff   <= nxt_done;
         write_collision_flag_ff   <= nxt_write_collision_flag;
         mode_fault_flag_ff   <= nxt_mode_fault_flag;
         ovr_ff    <= nxt_ovr;
         irq_ff    <= nxt_irq;
         sck_ff    <= nxt_sck;
         sckoe_ff  <= nxt_sckoe;
         mosi_ff   <= nxt_mosi;
         misooe_ff <= nxt_misooe;
         nsso_ff   <= nxt_nsso;
         nssoe_ff  <= nxt_nssoe;
         sync1_ff  <= {slave_select_i, miso_i, mosi_i, sck_i};
         sync2_ff  <= sync1_ff;
         sckp_ff   <= sync2_ff[0];
      end
   end

   property p_slave_sample;
      @(posedge clock) disable iff (!nrst)
      (state_ff == ST_SLAVE && selected && en_ff && sample_edge)
      |=> shift_ff[0] == $past(mosi_s);
   endproperty
   a_slave_sample: assert property (p_slave_sample)
      else $error("slave did not take mosi on the sample edge");

   property p_master_sample;
      @(posedge clock) disable iff (!nrst)
      (state_ff == ST_MASTER && en_ff && half_ff && cnt_ff == ckr_ff)
      |=> shift_ff[0] == $past(miso_s);
   endproperty
   a_master_sample: assert property (p_master_sample)
      else $error("master did not sample miso in the last bit clock");

   property p_done;
      @(posedge clock) disable iff (!nrst)
      ev_done |=> done_ff && irq_ff;
   endproperty
   a_done: assert property (p_done)
      else $error("transfer end did not raise done flag and interrupt");

   property p_write_collision_flag;
      @(posedge clock) disable iff (!nrst)
      (wr_dat && !txe_ff) |=> write_collision_flag_ff && txbuf_ff == $past(txbuf_ff);
   endproperty
   a_write_collision_flag: assert property (p_write_collision_flag)
      else $error("collision write changed buffer or missed flag");

   property p_mode_fault_flag;
      @(posedge clock) disable iff (!nrst)
      (mst_ff && sel_ff == SEL_4WIRE_IN && !nss_s) |=> mode_fault_flag_ff && irq_ff;
   endproperty
   a_mode_fault_flag: assert property (p_mode_fault_flag)
      else $error("mode fault not flagged");

   property p_ovr;
      @(posedge clock) disable iff (!nrst)
      (state_ff == ST_SLAVE && en_ff && selected && sample_edge
       && bit_ff == BIT_LAST && !fifo_in_ready) |=> ovr_ff;
   endproperty
   a_ovr: assert property (p_ovr)
      else $error("receive overrun not flagged");

   property p_sel_out;
      @(posedge clock) disable iff (!nrst)
      sel_ff[1] |=> slave_select_oe && slave_select_o == $past(sel_ff[0]);
   endproperty
   a_sel_out: assert property (p_sel_out)
      else $error("select pin not driven from mode low bit");

   property p_txe;
      @(posedge clock) disable iff (!nrst)
      (wr_dat && txe_ff) |=> !txe_ff;
   endproperty
   a_txe: assert property (p_txe)
      else $error("buffer empty not cleared on accepted write");

   property p_txe_load;
      @(posedge clock) disable iff (!nrst)
      (state_ff == ST_IDLE && en_ff && mst_ff && !txe_ff && fifo_in_ready)
      |=> txe_ff && state_ff == ST_MASTER && shift_ff == $past(txbuf_ff);
   endproperty
   a_txe_load: assert property (p_txe_load)
      else $error("buffer not moved into shifter at transfer start");

   property p_disable;
      @(posedge clock) disable iff (!nrst)
      !en_ff |=> state_ff == ST_IDLE && !sck_oe && !miso_oe;
   endproperty
   a_disable: assert property (p_disable)
      else $error("disabled port still active");

   property p_half;
      @(posedge clock) disable iff (!nrst)
      (state_ff == ST_MASTER && en_ff && cnt_ff != ckr_ff)
      |=> half_ff == $past(half_ff) && cnt_ff == 8'($past(cnt_ff) + 1'b1);
   endproperty
   a_half: assert property (p_half)
      else $error("serial clock half period not divider plus one");

   property p_clear;
      @(posedge clock) disable iff (!nrst)
      (wr_ctl && !sfr_wdata[CTL_DONE] && !ev_done) |=> !done_ff;
   endproperty
   a_clear: assert property (p_clear)
      else $error("writing zero did not clear done flag");
endmodule : spicr_top

// >>> tb/spicr_partner.sv
// Purpose: Far-side SPI party: a slave while the port is master, and a
//          master task for slave-mode traffic.
// Assumes: Clock mode 0 (idle low, sample on rising edge) on both sides.
// Notes:   Released data lines show the inverse of their last value.
`timescale 1ns/1ps
module spicr_partner
(
   input  wire logic       clock,
   input  wire logic       sck_w,
   input  wire logic       mosi_w,
   input  wire logic       ss_w,
   input  wire logic [7:0] miso_byte,
   output logic            p_sck,
   output logic            p_mosi,
   output logic            p_miso,
   output logic            p_ss_n,
   output logic      [7:0] rx_byte
);
   logic       master_on;
   logic [7:0] tx_sh;

   initial
   begin
      master_on = 1'b0;
      p_sck     = 1'b0;
      p_mosi    = 1'b0;
      p_miso    = 1'b0;
      p_ss_n    = 1'b1;
      rx_byte   = 8'h00;
      tx_sh     = 8'h00;
   end

   // Selection loads the reply byte; its MSB is on the line at once.
   always @(negedge ss_w)
   begin
      if (!master_on)
      begin
         tx_sh  = miso_byte;
         p_miso = tx_sh[7];
      end
   end

   always @(posedge ss_w)
      p_miso = ~p_miso;

   always @(posedge sck_w)
   begin
      if (!master_on && !ss_w)
         rx_byte = {rx_byte[6:0], mosi_w};
   end

   always @(negedge sck_w)
   begin
      if (!master_on && !ss_w)
      begin
         tx_sh  = {tx_sh[6:0], 1'b0};
         p_miso = tx_sh[7];
      end
   end

   // Six system clocks per half bit keeps within the slave's rate limit.
   task automatic master_byte(input logic [7:0] b);
      master_on = 1'b1;
      p_ss_n    = 1'b0;
      repeat (6) @(negedge clock);
      for (int i = 7; i >= 0; i--)
      begin
         p_mosi = b[i];
         repeat (6) @(negedge clock);
         p_sck = 1'b1;
         repeat (6) @(negedge clock);
         p_sck = 1'b0;
      end
      repeat (6) @(negedge clock);
      p_mosi = ~p_mosi;
      p_ss_n = 1'b1;
      repeat (6) @(negedge clock);
      master_on = 1'b0;
   endtask : master_byte
endmodule : spicr_partner

// >>> tb/spi_control_and_clock_rate_test.sv
// Purpose: Self-checking bench for the SPI control and clock-rate block.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Pin levels are resolved here from the port's output enables.
`timescale 1ns/1ps
module spi_control_and_clock_rate_test import spicr_pkg::*;;
   logic       clock;
   logic       nrst;
   logic [7:0] sfr_addr;
   logic       sfr_wr;
   logic       sfr_rd;
   logic [7:0] sfr_wdata;
   logic [7:0] sfr_rdata;
   logic       port_irq;
   logic       sck_o;
   logic       sck_oe;
   logic       mosi_o;
   logic       mosi_oe;
   logic       miso_o;
   logic       miso_oe;
   logic       ss_o;
   logic       ss_oe;
   logic       p_sck;
   logic       p_mosi;
   logic       p_miso;
   logic       p_ss_n;
   logic       ss_pull_n;
   logic [7:0] miso_byte;
   logic [7:0] rx_byte;
   logic       sck_w;
   logic       mosi_w;
   logic       miso_w;
   logic       ss_w;
   int         bad_count;
   int         checks;

   assign sck_w  = sck_oe ? sck_o : p_sck;
   assign mosi_w = mosi_oe ? mosi_o : p_mosi;
   assign miso_w = miso_oe ? miso_o : p_miso;
   assign ss_w   = ss_oe ? ss_o : (p_ss_n & ss_pull_n);

   spicr_top uut (.clock(clock), .nrst(nrst), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .port_irq(port_irq), .sck_i(sck_w),
      .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
      .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
      .miso_oe(miso_oe), .slave_select_i(ss_w), .slave_select_o(ss_o),
      .slave_select_oe(ss_oe));

   spicr_partner peer (.clock(clock), .sck_w(sck_w), .mosi_w(mosi_w),
      .ss_w(ss_w), .miso_byte(miso_byte), .p_sck(p_sck),
      .p_mosi(p_mosi), .p_miso(p_miso), .p_ss_n(p_ss_n),
      .rx_byte(rx_byte));

   always #2.5 clock = ~clock;

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report

   task automatic check(input string name, input logic [15:0] seen,
                        input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error: %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr  = a;
      sfr_wdata = d;
      sfr_wr    = 1'b1;
      @(negedge clock);
      sfr_wr = 1'b0;
      @(negedge clock);
   endtask : reg_wr

   task automatic rd_chk(input string name, input logic [7:0] a,
                         input logic [7:0] exp);
      sfr_addr = a;
      sfr_rd   = 1'b1;
      @(negedge clock);
      sfr_rd = 1'b0;
      @(negedge clock);
      check(name, 16'(sfr_rdata), 16'(exp));
   endtask : rd_chk

   // Polls the serial clock or the interrupt until it shows level v.
   task automatic wait_for(input logic is_irq, input logic v,
                           output int n);
      n = 0;
      while (((is_irq ? port_irq : sck_o) !== v) && n < 5000)
      begin
         @(negedge clock);
         n++;
      end
      if (n >= 5000)
      begin
         bad_count++;
         $display("Error: wait expected %h seen timeout", v);
         final_report();
      end
   endtask : wait_for

   // One master byte: selects the peer, measures a clock period.
   task automatic xfer(input logic [7:0] div, input logic [7:0] txb,
                       input logic [7:0] rxb, input logic load);
      int n1;
      int n2;
      miso_byte = rxb;
      reg_wr(SPICR_ADDR_CKR, div);
      reg_wr(SPICR_ADDR_CTL, 8'h09);
      if (load)
         reg_wr(SPICR_ADDR_DAT, txb);
      wait_for(1'b0, 1'b0, n1);
      wait_for(1'b0, 1'b1, n1);
      wait_for(1'b0, 1'b0, n1);
      wait_for(1'b0, 1'b1, n2);
      check("sck period", 16'(n1 + n2), 16'(2 * (int'(div) + 1)));
      wait_for(1'b1, 1'b1, n1);
      rd_chk("rx data", SPICR_ADDR_DAT, rxb);
      check("peer byte", 16'(rx_byte), 16'(txb));
      rd_chk("control", SPICR_ADDR_CTL, 8'h8B);
      reg_wr(SPICR_ADDR_CTL, 8'h0D);
      @(negedge clock);
      check("irq", 16'(port_irq), 16'h0000);
      check("mosi enable", 16'(mosi_oe), 16'h0001);
      $display("test transfer divider %h done", div);
   endtask : xfer

   initial
   begin
      clock     = 1'b0;
      nrst      = 1'b0;
      sfr_addr  = 8'h00;
      sfr_wr    = 1'b0;
      sfr_rd    = 1'b0;
      sfr_wdata = 8'h00;
      ss_pull_n = 1'b1;
      miso_byte = 8'h00;
      bad_count = 0;
      checks    = 0;
      repeat (10) @(negedge clock);
      nrst = 1'b1;
      rd_chk("control", SPICR_ADDR_CTL, 8'h06);
      rd_chk("divider", SPICR_ADDR_CKR, CKR_RESET);
      rd_chk("unmapped", 8'h55, 8'h00);
      $display("test reset done");
      reg_wr(SPICR_ADDR_CFG, 8'h40);
      reg_wr(SPICR_ADDR_CTL, 8'h0C);
      check("select pin", 16'({ss_oe, ss_o}), 16'h0003);
      reg_wr(SPICR_ADDR_DAT, 8'hA5);
      rd_chk("control", SPICR_ADDR_CTL, 8'h0C);
      check("sck enable", 16'(sck_oe), 16'h0000);
      reg_wr(SPICR_ADDR_DAT, 8'h5A);
      rd_chk("control", SPICR_ADDR_CTL, 8'h4C);
      check("irq", 16'(port_irq), 16'h0001);
      reg_wr(SPICR_ADDR_CTL, 8'h0C);
      rd_chk("control", SPICR_ADDR_CTL, 8'h0C);
      $display("test collision done");
      xfer(8'h01, 8'hA5, 8'h3C, 1'b0);
      // Seven is a divider between the 01 and FF transfers run around it.
      xfer(8'h07, 8'hC3, 8'h96, 1'b1);
      xfer(8'hFF, 8'h81, 8'h7E, 1'b1);
      reg_wr(SPICR_ADDR_CTL, 8'h05);
      ss_pull_n = 1'b0;
      repeat (5) @(negedge clock);
      rd_chk("control", SPICR_ADDR_CTL, 8'h27);
      check("irq", 16'(port_irq), 16'h0001);
      check("select enable", 16'(ss_oe), 16'h0000);
      ss_pull_n = 1'b1;
      // The fault keeps setting until the select synchroniser sees high.
      repeat (3) @(negedge clock);
      reg_wr(SPICR_ADDR_CTL, 8'h05);
      rd_chk("control", SPICR_ADDR_CTL, 8'h07);
      reg_wr(SPICR_ADDR_CTL, 8'h01);
      ss_pull_n = 1'b0;
      repeat (5) @(negedge clock);
      rd_chk("control", SPICR_ADDR_CTL, 8'h03);
      ss_pull_n = 1'b1;
      $display("test mode fault done");
      reg_wr(SPICR_ADDR_CTL, 8'h04);
      reg_wr(SPICR_ADDR_CFG, 8'h00);
      reg_wr(SPICR_ADDR_CTL, 8'h05);
      for (int i = 0; i < FIFO_DEPTH; i++)
         peer.master_byte(8'(8'h40 + i));
      rd_chk("control", SPICR_ADDR_CTL, 8'h87);
      peer.master_byte(8'hEE);
      rd_chk("control", SPICR_ADDR_CTL, 8'h97);
      rd_chk("rx data", SPICR_ADDR_DAT, 8'h40);
      check("miso enable", 16'(miso_oe), 16'h0000);
      $display("test slave overrun done");
      final_report();
   end
endmodule : spi_control_and_clock_rate_test
